// ==== common/pwm_regs.svh ====
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

// Register indices on the byte-wide register port
`define REG_PIN_DIRECTION 4'h0
`define REG_FLAGS_ONE 4'h1
`define REG_ENABLE_ONE 4'h2
`define REG_PRIORITY_ONE 4'h3
`define REG_FLAGS_TWO 4'h4
`define REG_TIMER_COUNT 4'h5
`define REG_TIMER_CONTROL 4'h6
`define REG_PERIOD_MATCH 4'h7
`define REG_DUTY_LOW 4'h8
`define REG_DUTY_SHADOW 4'h9
`define REG_MOD_CONTROL 4'ha
`define REG_SHUTDOWN_CONTROL 4'hb
`define REG_RESTART_DEADBAND 4'hc

// Reset values
`define RST_PIN_DIRECTION 4'hf
`define RST_BYTE 8'h00
`define RST_PRIORITY_ONE 8'hff

// Field positions
`define BIT_PERIOD_MATCH_FLAG 1
`define BIT_OSC_FAIL_FLAG 7
`define BIT_TIMER_RUN 2
`define TIMER_CONTROL_MASK 8'h7f
`define BIT_SHUTDOWN_STATUS 7
`define BIT_AUTO_RESTART 7
`define MASK_OSC_FAIL 8'h80
`define MASK_PERIOD_MATCH 8'h02

`endif

// ==== common/pwm_pkg.sv ====
package pwm_pkg;

  typedef enum logic [1:0] {
    cfg_single = 2'b00,
    cfg_full_forward = 2'b01,
    cfg_half_bridge = 2'b10,
    cfg_full_reverse = 2'b11
  } output_config_type;

  typedef enum logic [3:0] {
    db_b_on = 4'b0001,
    db_wait_a = 4'b0010,
    db_a_on = 4'b0100,
    db_wait_b = 4'b1000
  } deadband_state_type;

endpackage

// ==== common/deadband_if.sv ====
interface deadband_if;
  logic drive;
  logic [6:0] delay;
  logic hold;
  logic a_on;
  logic b_on;

  modport source (output drive, output delay, output hold, input a_on, input b_on);
  modport sink (input drive, input delay, input hold, output a_on, output b_on);
endinterface

// ==== hdl/deadband_gen.sv ====
module deadband_gen
  import pwm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  deadband_if.sink db
);

  deadband_state_type state_q;
  logic [6:0] count_q;

  // Each complementary edge waits the programmed count before turning on
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= db_b_on;
      count_q <= 7'h00;
    end
    else if (!db.hold)
    begin
      unique case (state_q)
        db_b_on:
          if (db.drive)
          begin
            state_q <= (db.delay == 7'h00) ? db_a_on : db_wait_a;
            count_q <= db.delay;
          end
        db_wait_a:
          if (!db.drive)
            state_q <= db_b_on;
          else if (count_q <= 7'h01)
            state_q <= db_a_on;
          else
            count_q <= count_q - 7'h01;
        db_a_on:
          if (!db.drive)
          begin
            state_q <= (db.delay == 7'h00) ? db_b_on : db_wait_b;
            count_q <= db.delay;
          end
        db_wait_b:
          if (db.drive)
            state_q <= db_a_on;
          else if (count_q <= 7'h01)
            state_q <= db_b_on;
          else
            count_q <= count_q - 7'h01;
        default:
          state_q <= db_b_on;
      endcase
    end
  end

  assign db.a_on = (state_q == db_a_on);
  assign db.b_on = (state_q == db_b_on);

endmodule // deadband_gen

// ==== hdl/enhanced_pwm.sv ====
`include "pwm_regs.svh"

module enhanced_pwm
  import pwm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic fault_input_pin_n,
  input wire logic comparator_one,
  input wire logic comparator_two,
  input wire logic sleep_mode,
  input wire logic primary_idle_mode,
  input wire logic managed_mode,
  input wire logic managed_tick,
  input wire logic fail_monitor_enable,
  input wire logic clock_failed,
  input wire logic internal_oscillator_tick,
  output logic internal_mode_a,
  output logic out_a,
  output logic out_a_oe,
  output logic out_b,
  output logic out_b_oe,
  output logic out_c,
  output logic out_c_oe,
  output logic out_d,
  output logic out_d_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible state

  logic [3:0] pin_direction_bits_q;
  logic [7:0] enable_one_q;
  logic [7:0] priority_one_q;
  logic period_match_flag_q;
  logic oscillator_fail_flag_q;
  logic [7:0] timer_count_q;
  logic [6:0] timer_control_q;
  logic [7:0] period_match_value_q;
  logic [7:0] duty_cycle_low_q;
  logic [7:0] duty_shadow_q;
  logic [1:0] duty_shadow_low_q;
  logic [7:0] modulator_control_q;
  logic [6:0] shutdown_config_q;
  logic shutdown_status_bit_q;
  logic [7:0] restart_deadband_control_q;

  logic wr_pin_dir;
  logic wr_flags_one;
  logic wr_flags_two;
  logic wr_timer_count;
  logic wr_timer_control;
  logic wr_shutdown;

  // Decoded once, used by every write process except the plain configuration registers, which decode reg_addr themselves
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] index, input logic strobe);
    hit = strobe && (addr == index);
  endfunction

  assign wr_pin_dir = hit(reg_addr, `REG_PIN_DIRECTION, reg_write);
  assign wr_flags_one = hit(reg_addr, `REG_FLAGS_ONE, reg_write);
  assign wr_flags_two = hit(reg_addr, `REG_FLAGS_TWO, reg_write);
  assign wr_timer_count = hit(reg_addr, `REG_TIMER_COUNT, reg_write);
  assign wr_timer_control = hit(reg_addr, `REG_TIMER_CONTROL, reg_write);
  assign wr_shutdown = hit(reg_addr, `REG_SHUTDOWN_CONTROL, reg_write);

  ////////////////////////////////////////////////////////////////////////////
  // Clock selection and freeze

  logic fail_mode_q;
  logic advance;

  // Fail-over is sticky until reset; the primary clock is not trusted again
  always_ff @(posedge clock)
  begin
    if (rst)
      fail_mode_q <= 1'b0;
    else if (fail_monitor_enable && clock_failed)
      fail_mode_q <= 1'b1;
  end

  assign internal_mode_a = fail_mode_q;

  always_comb
  begin
    if (sleep_mode)
      advance = 1'b0;
    else if (fail_mode_q)
      advance = internal_oscillator_tick;
    else if (primary_idle_mode || !managed_mode)
      advance = 1'b1;
    else
      advance = managed_tick;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain configuration registers

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pin_direction_bits_q <= `RST_PIN_DIRECTION;
      enable_one_q <= `RST_BYTE;
      priority_one_q <= `RST_PRIORITY_ONE;
      period_match_value_q <= `RST_BYTE;
      duty_cycle_low_q <= `RST_BYTE;
      modulator_control_q <= `RST_BYTE;
      restart_deadband_control_q <= `RST_BYTE;
    end
    else if (reg_write)
    begin
      unique case (reg_addr)
        `REG_PIN_DIRECTION: pin_direction_bits_q <= reg_wdata[3:0];
        `REG_ENABLE_ONE: enable_one_q <= reg_wdata;
        `REG_PRIORITY_ONE: priority_one_q <= reg_wdata;
        `REG_PERIOD_MATCH: period_match_value_q <= reg_wdata;
        `REG_DUTY_LOW: duty_cycle_low_q <= reg_wdata;
        `REG_MOD_CONTROL: modulator_control_q <= reg_wdata;
        `REG_RESTART_DEADBAND: restart_deadband_control_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      timer_control_q <= 7'h00;
    else if (wr_timer_control)
      timer_control_q <= reg_wdata[6:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period timer with prescaler

  logic [5:0] sub_q;
  logic [5:0] sub_last;
  logic [1:0] fine;
  logic timer_step;
  logic period_end;

  always_comb
  begin
    unique case (timer_control_q[1:0])
      2'b00: sub_last = 6'h03;
      2'b01: sub_last = 6'h0f;
      default: sub_last = 6'h3f;
    endcase
  end

  always_comb
  begin
    unique case (timer_control_q[1:0])
      2'b00: fine = sub_q[1:0];
      2'b01: fine = sub_q[3:2];
      default: fine = sub_q[5:4];
    endcase
  end

  assign timer_step = advance && timer_control_q[`BIT_TIMER_RUN] && (sub_q >= sub_last);
  assign period_end = timer_step && (timer_count_q == period_match_value_q);

  always_ff @(posedge clock)
  begin
    if (rst)
      sub_q <= 6'h00;
    else if (wr_timer_count || wr_timer_control)
      sub_q <= 6'h00;
    else if (advance && timer_control_q[`BIT_TIMER_RUN])
      sub_q <= (sub_q >= sub_last) ? 6'h00 : sub_q + 6'h01;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      timer_count_q <= `RST_BYTE;
    else if (wr_timer_count)
      timer_count_q <= reg_wdata;
    else if (period_end)
      timer_count_q <= 8'h00;
    else if (timer_step)
      timer_count_q <= timer_count_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: hardware set beats a software clear in the same cycle

  always_ff @(posedge clock)
  begin
    if (rst)
      period_match_flag_q <= 1'b0;
    else if (period_end)
      period_match_flag_q <= 1'b1;
    else if (wr_flags_one)
      period_match_flag_q <= reg_wdata[`BIT_PERIOD_MATCH_FLAG];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      oscillator_fail_flag_q <= 1'b0;
    else if (fail_monitor_enable && clock_failed && !fail_mode_q)
      oscillator_fail_flag_q <= 1'b1;
    else if (wr_flags_two)
      oscillator_fail_flag_q <= reg_wdata[`BIT_OSC_FAIL_FLAG];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty latch at each period start

  logic [9:0] duty_active;
  logic [9:0] timebase;
  logic drive;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      duty_shadow_q <= `RST_BYTE;
      duty_shadow_low_q <= 2'b00;
    end
    else if (period_end)
    begin
      // Loading only here keeps a mid-period write from giving a runt pulse
      duty_shadow_q <= duty_cycle_low_q;
      duty_shadow_low_q <= modulator_control_q[5:4];
    end
  end

  assign duty_active = {duty_shadow_q, duty_shadow_low_q};
  assign timebase = {timer_count_q, fine};
  assign drive = timebase < duty_active;

  ////////////////////////////////////////////////////////////////////////////
  // Auto-shutdown

  logic shutdown_condition;
  logic shutdown_output_q;

  // Source decode; the fault pin is active low
  function automatic logic source_hit(input logic [2:0] sel, input logic flt_n, input logic c1, input logic c2);
    logic cmp;
    cmp = (sel[0] && c1) || (sel[1] && c2);
    source_hit = cmp || (sel[2] && !flt_n);
  endfunction

  assign shutdown_condition = source_hit(shutdown_config_q[6:4], fault_input_pin_n, comparator_one,
                                         comparator_two);

  always_ff @(posedge clock)
  begin
    if (rst)
      shutdown_config_q <= 7'h00;
    else if (wr_shutdown)
      shutdown_config_q <= reg_wdata[6:0];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      shutdown_status_bit_q <= 1'b0;
    else if (sleep_mode)
      shutdown_status_bit_q <= shutdown_status_bit_q;
    else if (shutdown_condition)
      shutdown_status_bit_q <= 1'b1;
    else if (wr_shutdown)
      shutdown_status_bit_q <= reg_wdata[`BIT_SHUTDOWN_STATUS];
    else if (restart_deadband_control_q[`BIT_AUTO_RESTART])
      shutdown_status_bit_q <= 1'b0;
  end

  // Outputs leave shutdown only on a period boundary
  always_ff @(posedge clock)
  begin
    if (rst)
      shutdown_output_q <= 1'b0;
    else if (shutdown_status_bit_q)
      shutdown_output_q <= 1'b1;
    else if (period_end)
      shutdown_output_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dead band and pin steering

  deadband_if db_link ();
  output_config_type config_sel;
  logic pwm_mode;
  logic [3:0] active;
  logic [3:0] invert;
  logic [3:0] modulated;
  logic [3:0] pin_value;
  logic [3:0] pin_enable;

  assign db_link.drive = drive;
  assign db_link.delay = restart_deadband_control_q[6:0];
  assign db_link.hold = !advance;

  deadband_gen i_deadband_gen (
    .clock(clock),
    .rst(rst),
    .db(db_link)
  );

  assign config_sel = output_config_type'(modulator_control_q[7:6]);
  assign pwm_mode = (modulator_control_q[3:2] == 2'b11);
  assign invert = {modulator_control_q[0], modulator_control_q[1], modulator_control_q[0], modulator_control_q[1]};

  always_comb
  begin
    unique case (config_sel)
      cfg_single:
      begin
        active = {3'b000, drive};
        modulated = 4'b0001;
      end
      cfg_full_forward:
      begin
        active = {drive, 3'b001};
        modulated = 4'b1001;
      end
      cfg_half_bridge:
      begin
        active = {2'b00, db_link.b_on, db_link.a_on};
        modulated = 4'b0011;
      end
      cfg_full_reverse:
      begin
        active = {1'b0, 1'b1, drive, 1'b0};
        modulated = 4'b0110;
      end
    endcase
  end

  // Pin level per pair while shut down: 00 low, 01 high, 1x released
  function automatic logic [1:0] shutdown_pin(input logic [1:0] level, input logic dir_in);
    shutdown_pin = {!level[1] && !dir_in, level[0]};
  endfunction

  genvar pin;
  generate
    for (pin = 0; pin < 4; pin++)
    begin : g_pin
      logic [1:0] level;
      logic [1:0] sd;
      assign level = (pin % 2 == 1) ? shutdown_config_q[1:0] : shutdown_config_q[3:2];
      assign sd = shutdown_pin(level, pin_direction_bits_q[pin]);
      always_comb
      begin
        if (pwm_mode && modulated[pin] && shutdown_output_q)
        begin
          pin_value[pin] = sd[0];
          pin_enable[pin] = sd[1];
        end
        else if (pwm_mode && modulated[pin])
        begin
          pin_value[pin] = active[pin] ^ invert[pin];
          pin_enable[pin] = !pin_direction_bits_q[pin];
        end
        else
        begin
          pin_value[pin] = 1'b0;
          pin_enable[pin] = !pin_direction_bits_q[pin];
        end
      end
    end
  endgenerate

  // Pins hold their last level across sleep
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      {out_d, out_c, out_b, out_a} <= 4'h0;
      {out_d_oe, out_c_oe, out_b_oe, out_a_oe} <= 4'h0;
    end
    else if (!sleep_mode)
    begin
      {out_d, out_c, out_b, out_a} <= pin_value;
      {out_d_oe, out_c_oe, out_b_oe, out_a_oe} <= pin_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always_ff @(posedge clock)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      unique case (reg_addr)
        `REG_PIN_DIRECTION: reg_rdata <= {4'h0, pin_direction_bits_q};
        `REG_FLAGS_ONE: reg_rdata <= period_match_flag_q ? `MASK_PERIOD_MATCH : 8'h00;
        `REG_ENABLE_ONE: reg_rdata <= enable_one_q;
        `REG_PRIORITY_ONE: reg_rdata <= priority_one_q;
        `REG_FLAGS_TWO: reg_rdata <= oscillator_fail_flag_q ? `MASK_OSC_FAIL : 8'h00;
        `REG_TIMER_COUNT: reg_rdata <= timer_count_q;
        `REG_TIMER_CONTROL: reg_rdata <= {1'b0, timer_control_q} & `TIMER_CONTROL_MASK;
        `REG_PERIOD_MATCH: reg_rdata <= period_match_value_q;
        `REG_DUTY_LOW: reg_rdata <= duty_cycle_low_q;
        `REG_DUTY_SHADOW: reg_rdata <= duty_shadow_q;
        `REG_MOD_CONTROL: reg_rdata <= modulator_control_q;
        `REG_SHUTDOWN_CONTROL: reg_rdata <= {shutdown_status_bit_q, shutdown_config_q};
        `REG_RESTART_DEADBAND: reg_rdata <= restart_deadband_control_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule // enhanced_pwm

// ==== verif/enhanced_pwm_asserts.sv ====
`include "pwm_regs.svh"

module enhanced_pwm_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic fault_input_pin_n,
  input wire logic comparator_one,
  input wire logic comparator_two,
  input wire logic sleep_mode,
  input wire logic fail_monitor_enable,
  input wire logic clock_failed,
  input wire logic internal_mode_a,
  input wire logic out_a,
  input wire logic out_a_oe,
  input wire logic out_b,
  input wire logic out_b_oe,
  input wire logic out_c_oe,
  input wire logic out_d_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] sdc_q;
  logic restart_q;
  logic b_dir_q;
  logic [7:0] mod_q;
  logic cond_w;

  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////
  // Shadows of software writes, so conditions follow the setup
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sdc_q <= 8'h00;
      restart_q <= 1'b0;
      b_dir_q <= 1'b1;
      mod_q <= 8'h00;
    end
    else if (reg_write)
    begin
      if (reg_addr == `REG_SHUTDOWN_CONTROL)
        sdc_q <= reg_wdata;
      if (reg_addr == `REG_RESTART_DEADBAND)
        restart_q <= reg_wdata[7];
      if (reg_addr == `REG_PIN_DIRECTION)
        b_dir_q <= reg_wdata[1];
      if (reg_addr == `REG_MOD_CONTROL)
        mod_q <= reg_wdata;
    end
  end

  // Source bits decode independently, so the OR combinations fall out
  assign cond_w = (sdc_q[6] & ~fault_input_pin_n) | (sdc_q[4] & comparator_one) | (sdc_q[5] & comparator_two);

  ////////////////////////////////////////////////////////////////
  property p_reset_quiet;
    $fell(rst) |-> {out_a, out_b, out_a_oe, out_b_oe, out_c_oe, out_d_oe} == 6'h00 && reg_rdata == 8'h00;
  endproperty
  property p_sleep_hold;
    sleep_mode |=> $stable({out_a, out_a_oe, out_b, out_b_oe, out_c_oe, out_d_oe});
  endproperty
  property p_fail_enter;
    fail_monitor_enable && clock_failed |-> ##[0:4] internal_mode_a;
  endproperty
  property p_fail_keep;
    internal_mode_a |=> internal_mode_a;
  endproperty
  property p_status_set;
    cond_w && $past(cond_w) && !$past(sleep_mode) && reg_read && reg_addr == `REG_SHUTDOWN_CONTROL |=> reg_rdata[7];
  endproperty
  property p_auto_clear;
    restart_q && !cond_w && !$past(cond_w) && !$past(cond_w, 2) && !$past(reg_write) && !$past(reg_write, 2)
      && !$past(sleep_mode) && reg_read && reg_addr == `REG_SHUTDOWN_CONTROL |=> !reg_rdata[7];
  endproperty
  property p_release_ac;
    // Only modulated pins follow the shutdown level: C in reverse, A otherwise
    cond_w && sdc_q[3] && mod_q[3:2] == 2'b11 |-> ##[1:3] (mod_q[7:6] == 2'b11 ? !out_c_oe : !out_a_oe);
  endproperty
  property p_bd_high;
    cond_w && $past(cond_w) && $past(cond_w, 2) && $past(cond_w, 3) && !$past(reg_write) && !$past(sleep_mode)
      && sdc_q[1:0] == 2'b01 && !b_dir_q && mod_q[7] && mod_q[3:2] == 2'b11 |-> out_b && out_b_oe;
  endproperty

  a_reset_quiet: assert property (p_reset_quiet) else $error("pins or read data busy after reset");
  a_sleep_hold: assert property (p_sleep_hold) else $error("pins moved in sleep");
  a_fail_enter: assert property (p_fail_enter) else $error("no fail-over mode");
  a_fail_keep: assert property (p_fail_keep) else $error("fail-over mode dropped");
  a_status_set: assert property (p_status_set) else $error("status low during fault");
  a_auto_clear: assert property (p_auto_clear) else $error("status not restarted");
  a_release_ac: assert property (p_release_ac) else $error("pair AC still driven");
  a_bd_high: assert property (p_bd_high) else $error("pair BD not high");

  c_status_read: cover property (cond_w && reg_read ##1 reg_rdata[7]);
  c_fail: cover property ($rose(internal_mode_a));
  c_sleep: cover property (sleep_mode [*4]);
endmodule // enhanced_pwm_asserts

bind enhanced_pwm enhanced_pwm_asserts i_enhanced_pwm_asserts (
  .clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .fault_input_pin_n, .comparator_one, .comparator_two, .sleep_mode, .fail_monitor_enable,
  .clock_failed, .internal_mode_a, .out_a, .out_a_oe, .out_b, .out_b_oe, .out_c_oe, .out_d_oe
);

// ==== verif/pwm_switch_model.sv ====
module pwm_switch_model (
  input wire logic clock,
  input wire logic clear,
  input wire logic [3:0] drive,
  input wire logic [3:0] drive_oe,
  output logic [3:0] level,
  output int high_a,
  output int overlap,
  output int both_off
);
  timeunit 1ns;
  timeprecision 100ps;

  // Pull-downs hold a released switch off
  assign level = drive & drive_oe;

  always @(posedge clock)
  begin
    if (clear)
    begin
      high_a <= 0;
      overlap <= 0;
      both_off <= 0;
    end
    else
    begin
      high_a <= high_a + level[0];
      overlap <= overlap + (level[0] & level[1]);
      both_off <= both_off + (!level[0] & !level[1]);
    end
  end
endmodule // pwm_switch_model

// ==== verif/enhanced_pwm_tb.sv ====
`include "pwm_regs.svh"

module enhanced_pwm_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic fault_input_pin_n = 1'b1;
  logic comparator_one = 1'b0;
  logic comparator_two = 1'b0;
  logic sleep_mode = 1'b0;
  logic primary_idle_mode = 1'b0;
  logic managed_mode = 1'b0;
  logic managed_tick = 1'b0;
  logic fail_monitor_enable = 1'b0;
  logic clock_failed = 1'b0;
  logic internal_oscillator_tick = 1'b0;
  logic internal_mode_a;
  logic [3:0] drv;
  logic [3:0] oe;
  logic [3:0] level;
  logic clear = 1'b1;
  logic tick_en = 1'b0;
  logic [31:0] rnd_q = 32'h00000000;
  logic [7:0] rv;
  int high_a;
  int overlap;
  int both_off;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'he9a4e3c1;

  enhanced_pwm i_enhanced_pwm (
    .clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .fault_input_pin_n, .comparator_one, .comparator_two, .sleep_mode, .primary_idle_mode,
    .managed_mode, .managed_tick, .fail_monitor_enable, .clock_failed, .internal_oscillator_tick,
    .internal_mode_a, .out_a(drv[0]), .out_a_oe(oe[0]), .out_b(drv[1]), .out_b_oe(oe[1]),
    .out_c(drv[2]), .out_c_oe(oe[2]), .out_d(drv[3]), .out_d_oe(oe[3])
  );
  pwm_switch_model i_pwm_switch_model (
    .clock, .clear, .drive(drv), .drive_oe(oe), .level, .high_a, .overlap, .both_off
  );

  always #2.5 clock = ~clock;

  always @(posedge clock)
  begin
    rnd_q <= $random(seed);
    managed_tick <= tick_en & rnd_q[0];
    internal_oscillator_tick <= rnd_q[1];
  end

  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Ends off the edge; caller checks, then realigns
  task automatic measure(input int n);
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic int high_cycles(input int duty, input int mult);
    return (duty < 20 ? duty : 20) * 4 * mult;
  endfunction

  function automatic logic src_hit(input logic [2:0] sel, input int src);
    return (sel[2] && src == 0) || (sel[0] && src == 1) || (sel[1] && src == 2);
  endfunction

  ////////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    int duty;
    int mult;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // Index 13 is unmapped and must read zero
    for (int i = 0; i < 14; i++)
    begin
      rd(i[3:0], rv);
      chk("reset value", i == 0 ? {4'h0, `RST_PIN_DIRECTION} : (i == 3 ? `RST_PRIORITY_ONE : 8'h00), rv);
    end
    $display("reset test done");
    wr(`REG_PIN_DIRECTION, 8'h0f);
    wr(`REG_PERIOD_MATCH, 8'h04);
    wr(`REG_SHUTDOWN_CONTROL, 8'h00);
    wr(`REG_MOD_CONTROL, 8'h2c);
    wr(`REG_DUTY_LOW, 8'h02);
    wr(`REG_SHUTDOWN_CONTROL, 8'h80);
    wr(`REG_FLAGS_ONE, 8'h00);
    wr(`REG_TIMER_CONTROL, 8'h04);
    n = 0;
    rv = 8'h00;
    while (rv[1] !== 1'b1 && n < 50)
    begin
      rd(`REG_FLAGS_ONE, rv);
      n++;
    end
    chk("period flag", 1'b1, rv[1]);
    wr(`REG_PIN_DIRECTION, 8'h00);
    wr(`REG_SHUTDOWN_CONTROL, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      duty = k == 0 ? 0 : (k == 1 ? 20 : int'(rnd_q[7:0]) % 22);
      mult = k == 3 ? 16 : (k[0] ? 4 : 1);
      wr(`REG_TIMER_CONTROL, k == 3 ? 8'h06 : (k[0] ? 8'h05 : 8'h04));
      wr(`REG_DUTY_LOW, 8'(duty >> 2));
      wr(`REG_MOD_CONTROL, {2'b00, 2'(duty), k == 2 ? 4'he : 4'hc});
      repeat (40 * mult) @(posedge clock);
      measure(80 * mult);
      chk("active cycles", k == 2 ? 80 - high_cycles(duty, 1) : high_cycles(duty, mult), high_a);
      @(posedge clock);
    end
    sleep_mode <= 1'b1;
    repeat (6) @(posedge clock);
    sleep_mode <= 1'b0;
    $display("duty test done");
    wr(`REG_TIMER_CONTROL, 8'h04);
    wr(`REG_RESTART_DEADBAND, 8'h05);
    wr(`REG_DUTY_LOW, 8'h02);
    wr(`REG_MOD_CONTROL, 8'hac);
    repeat (40) @(posedge clock);
    measure(80);
    chk("overlap cycles", 0, overlap);
    chk("dead cycles", 40, both_off);
    @(posedge clock);
    wr(`REG_MOD_CONTROL, 8'h6c);
    measure(80);
    chk("forward on cycles", 80, high_a);
    @(posedge clock);
    wr(`REG_MOD_CONTROL, 8'h2c);
    $display("dead band test done");
    for (int s = 0; s < 24; s++)
    begin
      wr(`REG_SHUTDOWN_CONTROL, {1'b0, 3'(s / 3), 4'h0});
      fault_input_pin_n <= s % 3 != 0;
      comparator_one <= s % 3 == 1;
      comparator_two <= s % 3 == 2;
      @(posedge clock);
      wr(`REG_SHUTDOWN_CONTROL, {1'b0, 3'(s / 3), 4'h0});
      rd(`REG_SHUTDOWN_CONTROL, rv);
      chk("status during fault", src_hit(3'(s / 3), s % 3), rv[7]);
      fault_input_pin_n <= 1'b1;
      comparator_one <= 1'b0;
      comparator_two <= 1'b0;
      repeat (3) @(posedge clock);
      rd(`REG_SHUTDOWN_CONTROL, rv);
      chk("status after fault", src_hit(3'(s / 3), s % 3), rv[7]);
      wr(`REG_SHUTDOWN_CONTROL, 8'h00);
      rd(`REG_SHUTDOWN_CONTROL, rv);
      chk("status cleared", 0, rv[7]);
    end
    // Half bridge, so both A and B are steered by the shutdown levels
    wr(`REG_MOD_CONTROL, 8'hac);
    wr(`REG_RESTART_DEADBAND, 8'h80);
    wr(`REG_SHUTDOWN_CONTROL, 8'h49);
    fault_input_pin_n <= 1'b0;
    repeat (4) @(posedge clock);
    #1 chk("pin levels", 4'b0010, level);
    @(posedge clock);
    fault_input_pin_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(`REG_SHUTDOWN_CONTROL, rv);
    chk("auto restart", 0, rv[7]);
    $display("shutdown test done");
    wr(`REG_PERIOD_MATCH, 8'hff);
    wr(`REG_TIMER_CONTROL, 8'h00);
    wr(`REG_TIMER_COUNT, 8'h03);
    repeat (20) @(posedge clock);
    rd(`REG_TIMER_COUNT, rv);
    chk("stopped timer", 8'h03, rv);
    managed_mode <= 1'b1;
    wr(`REG_TIMER_CONTROL, 8'h04);
    repeat (40) @(posedge clock);
    rd(`REG_TIMER_COUNT, rv);
    chk("tickless timer", 8'h03, rv);
    primary_idle_mode <= 1'b1;
    repeat (40) @(posedge clock);
    rd(`REG_TIMER_COUNT, rv);
    chk("idle timer moved", 1'b1, rv != 8'h03);
    primary_idle_mode <= 1'b0;
    tick_en <= 1'b1;
    wr(`REG_TIMER_COUNT, 8'h03);
    repeat (60) @(posedge clock);
    rd(`REG_TIMER_COUNT, rv);
    chk("ticked timer moved", 1'b1, rv != 8'h03);
    $display("power mode test done");
    fail_monitor_enable <= 1'b1;
    clock_failed <= 1'b1;
    n = 0;
    while (internal_mode_a !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    rd(`REG_FLAGS_TWO, rv);
    chk("fail mode", 1'b1, internal_mode_a);
    chk("oscillator fail flag", 1'b1, rv[7]);
    $display("fail-over test done");
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule // enhanced_pwm_tb
